/* File: i2c_rd_defs.vh */
// Constants for the ten-bit read tail of the I2C master.
// Assumes the including module runs on a single 50 MHz system clock.
`ifndef I2C_RD_DEFS_VH
`define I2C_RD_DEFS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define I2C_CLK_NS 20
`define I2C_SCL_PERIOD_NS 10000
`define I2C_QTR_CYC (`I2C_SCL_PERIOD_NS / (4 * `I2C_CLK_NS))
`define I2C_CNT_W 16

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define I2C_TEN_BIT_HDR 5'h1e
`define I2C_READ_BIT 1'b1
`define I2C_LAST_BIT 3'h0
`define I2C_FIRST_BIT 3'h7

// ----------------------------------------------------------------
// Quarter phases of one SCL bit slot
// ----------------------------------------------------------------
`define I2C_Q0 2'h0
`define I2C_Q2 2'h2
`define I2C_Q3 2'h3

// ----------------------------------------------------------------
// Receive buffer
// ----------------------------------------------------------------
`define I2C_BUF_DEPTH 2
`define I2C_BUF_PTR_W 1

`endif

/* File: i2c_rd_ctrl.v */
// I2C master: repeated START, third address byte and byte reception of a
// ten-bit-address read, with the data register and its receive buffer.
// Assumes software sits on the same clock and pulses its strobes for one
// cycle; the bus pins are open drain and resolved outside this module.
`timescale 1ns/1ps
`include "i2c_rd_defs.vh"

// Function
// - After both address bytes are acknowledged, issue a repeated START.
// - Third address transfer copies the data register into the shift register; the code takes only its bits 2:1.
// - Third address byte is 11110, two address MSBs, then read bit one.
// - Stop bit drives a STOP, then clears stop bit and not-acknowledge flag.
// - Shift in a byte, answer not-acknowledge if control bit set, else acknowledge.
// - Each received byte sets the receive-data-full flag.
// - Software reading the data register clears receive-data-full.
// - After final byte answered with not-acknowledge, raise not-acknowledge flag.
// - Data register holds outgoing byte for writes and received byte for reads.
// - Shift register is internal only, with no software access path.
module i2c_rd_ctrl #(
	parameter QTR_CYC = `I2C_QTR_CYC,
	parameter BUF_DEPTH = `I2C_BUF_DEPTH,
	parameter BUF_PTR_W = `I2C_BUF_PTR_W
) (
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	input wire restart_req,
	input wire stop_set,
	input wire flush_req,
	input wire nak_ctrl,
	input wire txi_clr,
	input wire data_wr,
	input wire [7:0] data_wdata,
	input wire data_rd,
	output wire [7:0] data_rdata,
	output wire stop_flag,
	output wire transmit_interrupt_flag,
	output wire not_ack_interrupt_flag,
	output wire receive_data_full_flag,
	output wire busy,
	input wire scl_i,
	output wire scl_o,
	output wire scl_oe,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe
);

	localparam [7:0] ST_IDLE = 8'h01;
	localparam [7:0] ST_RS = 8'h02;
	localparam [7:0] ST_ADDR = 8'h04;
	localparam [7:0] ST_AACK = 8'h08;
	localparam [7:0] ST_RXB = 8'h10;
	localparam [7:0] ST_RACK = 8'h20;
	localparam [7:0] ST_HOLD = 8'h40;
	localparam [7:0] ST_STOP = 8'h80;
	localparam [`I2C_CNT_W-1:0] QTR_LAST = QTR_CYC - 1;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// A level counts once the second and third stages agree, which
	// rejects a single-sample glitch on the open-drain lines.
	reg [2:0] scl_s_q;
	reg [2:0] sda_s_q;
	reg scl_f_q;
	reg sda_f_q;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else if (clk_en) begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			if (scl_s_q[1] == scl_s_q[2])
				scl_f_q <= scl_s_q[2];
			if (sda_s_q[1] == sda_s_q[2])
				sda_f_q <= sda_s_q[2];
		end
	end

	// ----------------------------------------------------------------
	// Receive buffer
	// ----------------------------------------------------------------
	reg [7:0] buf_mem [0:BUF_DEPTH-1];
	reg [BUF_PTR_W-1:0] buf_wp_q;
	reg [BUF_PTR_W-1:0] buf_rp_q;
	reg [BUF_PTR_W:0] buf_cnt_q;
	reg receive_data_full_flag_q;
	wire buf_in_valid;
	wire [7:0] buf_in_data;
	wire buf_in_ready = (buf_cnt_q != BUF_DEPTH);
	wire buf_out_valid = (buf_cnt_q != {(BUF_PTR_W+1){1'b0}});
	wire buf_out_ready = !receive_data_full_flag_q;
	wire buf_push = buf_in_valid && buf_in_ready;
	wire buf_pop = buf_out_valid && buf_out_ready;

	function [BUF_PTR_W-1:0] ptr_inc;
		input [BUF_PTR_W-1:0] p;
		begin
			if (p == BUF_DEPTH - 1)
				ptr_inc = {BUF_PTR_W{1'b0}};
			else
				ptr_inc = p + 1'b1;
		end
	endfunction

	always @(posedge clk) begin
		if (clk_en && buf_push)
			buf_mem[buf_wp_q] <= buf_in_data;
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_wp_q <= {BUF_PTR_W{1'b0}};
			buf_rp_q <= {BUF_PTR_W{1'b0}};
			buf_cnt_q <= {(BUF_PTR_W+1){1'b0}};
		end else if (clk_en) begin
			if (flush_req) begin
				buf_wp_q <= {BUF_PTR_W{1'b0}};
				buf_rp_q <= {BUF_PTR_W{1'b0}};
				buf_cnt_q <= {(BUF_PTR_W+1){1'b0}};
			end else begin
				if (buf_push)
					buf_wp_q <= ptr_inc(buf_wp_q);
				if (buf_pop)
					buf_rp_q <= ptr_inc(buf_rp_q);
				if (buf_push && !buf_pop)
					buf_cnt_q <= buf_cnt_q + 1'b1;
				else if (buf_pop && !buf_push)
					buf_cnt_q <= buf_cnt_q - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Bit slot timing
	// ----------------------------------------------------------------
	reg [7:0] state_q;
	reg [7:0] state_d;
	reg [1:0] qtr_q;
	reg [`I2C_CNT_W-1:0] cnt_q;
	reg [2:0] bit_q;
	reg [7:0] sh_q;
	reg nak_sent_q;
	reg [7:0] data_q;
	reg txi_q;
	reg nck_q;
	reg stop_q;
	reg rx_more_q;
	reg scl_oe_q;
	reg sda_oe_q;
	reg scl_oe_d;
	reg sda_oe_d;

	wire timed = !(state_q == ST_IDLE || state_q == ST_HOLD);
	// A slave stretching SCL holds the first high quarter until it lets go.
	wire stretch = (qtr_q == `I2C_Q2) && !scl_f_q;
	wire tick = timed && (cnt_q == QTR_LAST) && !stretch;
	wire slot_end = tick && (qtr_q == `I2C_Q3);
	wire [7:0] rx_byte = {sh_q[6:0], sda_f_q};

	assign buf_in_valid = (state_q == ST_RXB) && slot_end && (bit_q == `I2C_LAST_BIT);
	assign buf_in_data = rx_byte;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always @* begin
		state_d = state_q;
		case (state_q)
		ST_IDLE: begin
			if (restart_req)
				state_d = ST_RS;
		end
		ST_RS: begin
			if (slot_end)
				state_d = ST_ADDR;
		end
		ST_ADDR: begin
			if (slot_end && bit_q == `I2C_LAST_BIT)
				state_d = ST_AACK;
		end
		ST_AACK: begin
			if (slot_end) begin
				if (!sda_f_q && buf_in_ready)
					state_d = ST_RXB;
				else
					state_d = ST_HOLD;
			end
		end
		ST_RXB: begin
			if (slot_end && bit_q == `I2C_LAST_BIT)
				state_d = ST_RACK;
		end
		ST_RACK: begin
			if (slot_end) begin
				if (!nak_sent_q && buf_in_ready)
					state_d = ST_RXB;
				else
					state_d = ST_HOLD;
			end
		end
		ST_HOLD: begin
			if (stop_q)
				state_d = ST_STOP;
			else if (restart_req)
				state_d = ST_RS;
			else if (rx_more_q && buf_in_ready)
				state_d = ST_RXB;
		end
		ST_STOP: begin
			if (slot_end)
				state_d = ST_IDLE;
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	// SCL is low in the first half of every address, data and acknowledge slot and released in the
	// second; SDA only moves while SCL is low except for START and STOP.
	// SDA waits one quarter after SCL falls so it never moves on that edge,
	// and START and STOP wait out a slave that stretches SCL.
	always @* begin
		scl_oe_d = 1'b0;
		sda_oe_d = 1'b0;
		case (state_q)
		ST_RS: begin
			scl_oe_d = (qtr_q == `I2C_Q0) || (qtr_q == `I2C_Q3);
			sda_oe_d = qtr_q[1] && !stretch;
		end
		ST_ADDR: begin
			scl_oe_d = !qtr_q[1];
			sda_oe_d = (qtr_q == `I2C_Q0) ? sda_oe_q : !sh_q[7];
		end
		ST_AACK: begin
			scl_oe_d = !qtr_q[1];
			sda_oe_d = (qtr_q == `I2C_Q0) && sda_oe_q;
		end
		ST_RXB: begin
			scl_oe_d = !qtr_q[1];
			sda_oe_d = (qtr_q == `I2C_Q0) && sda_oe_q;
		end
		ST_RACK: begin
			scl_oe_d = !qtr_q[1];
			sda_oe_d = (qtr_q == `I2C_Q0) ? sda_oe_q : !nak_sent_q;
		end
		ST_HOLD: begin
			scl_oe_d = 1'b1;
			sda_oe_d = sda_oe_q || !scl_f_q;
		end
		ST_STOP: begin
			scl_oe_d = (qtr_q == `I2C_Q0);
			sda_oe_d = !qtr_q[1] || stretch;
		end
		default: begin
			scl_oe_d = 1'b0;
			sda_oe_d = 1'b0;
		end
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			qtr_q <= `I2C_Q0;
			cnt_q <= {`I2C_CNT_W{1'b0}};
			bit_q <= `I2C_FIRST_BIT;
			sh_q <= 8'h00;
			nak_sent_q <= 1'b0;
			rx_more_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (clk_en) begin
			state_q <= state_d;
			scl_oe_q <= scl_oe_d;
			sda_oe_q <= sda_oe_d;
			if (state_d != state_q || !timed) begin
				qtr_q <= `I2C_Q0;
				cnt_q <= {`I2C_CNT_W{1'b0}};
			end else if (tick) begin
				qtr_q <= qtr_q + 1'b1;
				cnt_q <= {`I2C_CNT_W{1'b0}};
			end else if (!stretch) begin
				cnt_q <= cnt_q + 1'b1;
			end
			if (state_q == ST_RS && slot_end) begin
				sh_q <= {`I2C_TEN_BIT_HDR, data_q[2:1], `I2C_READ_BIT};
				bit_q <= `I2C_FIRST_BIT;
			end else if ((state_q == ST_ADDR || state_q == ST_RXB) && slot_end) begin
				sh_q <= (state_q == ST_ADDR) ? {sh_q[6:0], 1'b0} : rx_byte;
				bit_q <= bit_q - 1'b1;
			end
			if (state_q == ST_RXB && slot_end && bit_q == `I2C_LAST_BIT)
				nak_sent_q <= nak_ctrl;
			if (state_d == ST_RXB || (state_q == ST_AACK && slot_end && !sda_f_q))
				rx_more_q <= 1'b1;
			else if (state_d == ST_IDLE || state_d == ST_RS || nck_q)
				rx_more_q <= 1'b0;
			// A NAK either way must end reception before HOLD can resume it.
			if (slot_end && ((state_q == ST_AACK && sda_f_q) ||
					(state_q == ST_RACK && nak_sent_q)))
				rx_more_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software-visible flags and data register
	// ----------------------------------------------------------------
	// Every hardware set below takes priority over a clear in the same cycle.
	wire nck_set = slot_end && ((state_q == ST_AACK && sda_f_q) || (state_q == ST_RACK && nak_sent_q));
	wire stop_done = state_q == ST_STOP && slot_end;
	wire txi_set = state_q == ST_RS && slot_end;

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			data_q <= 8'h00;
			receive_data_full_flag_q <= 1'b0;
			txi_q <= 1'b0;
			nck_q <= 1'b0;
			stop_q <= 1'b0;
		end else if (clk_en) begin
			if (buf_pop)
				data_q <= buf_mem[buf_rp_q];
			else if (data_wr)
				data_q <= data_wdata;
			if (buf_pop)
				receive_data_full_flag_q <= 1'b1;
			else if (data_rd || flush_req)
				receive_data_full_flag_q <= 1'b0;
			if (txi_set)
				txi_q <= 1'b1;
			else if (txi_clr || data_wr)
				txi_q <= 1'b0;
			if (nck_set)
				nck_q <= 1'b1;
			else if (stop_done || (state_q == ST_IDLE && stop_q))
				nck_q <= 1'b0;
			if (stop_set)
				stop_q <= 1'b1;
			else if (stop_done || state_q == ST_IDLE)
				stop_q <= 1'b0;
		end
	end

	assign data_rdata = data_q;
	assign stop_flag = stop_q;
	assign transmit_interrupt_flag = txi_q;
	assign not_ack_interrupt_flag = nck_q;
	assign receive_data_full_flag = receive_data_full_flag_q;
	assign busy = (state_q != ST_IDLE);
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;

endmodule // i2c_rd_ctrl

/* File: i2c_rd_ctrl_assertions.sv */
// Port-level checks for the ten-bit read controller.
// Assumes a single clock domain; attached to every controller instance.
`timescale 1ns/1ps
module i2c_rd_chk (
	input wire clk,
	input wire rst_b,
	input wire clk_en,
	input wire restart_req,
	input wire stop_set,
	input wire data_wr,
	input wire [7:0] data_wdata,
	input wire data_rd,
	input wire [7:0] data_rdata,
	input wire stop_flag,
	input wire transmit_interrupt_flag,
	input wire not_ack_interrupt_flag,
	input wire receive_data_full_flag,
	input wire busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_start_goes_busy: assert property (restart_req && clk_en && !busy |=> busy)
		else $error("restart did not start");
	a_load_while_busy: assert property ($rose(transmit_interrupt_flag) |-> busy)
		else $error("shift load outside a transfer");
	a_write_loads: assert property (data_wr && clk_en && !busy |=>
		data_rdata == $past(data_wdata) && !transmit_interrupt_flag)
		else $error("data write lost");
	a_read_clears: assert property (data_rd && clk_en && receive_data_full_flag |=>
		!receive_data_full_flag)
		else $error("read left full flag");
	a_full_holds: assert property (receive_data_full_flag && !data_rd && !data_wr |=>
		$stable(data_rdata))
		else $error("unread byte overwritten");
	a_load_sets_full: assert property ($changed(data_rdata) && !$past(data_wr) |->
		receive_data_full_flag)
		else $error("byte loaded without full flag");
	a_idle_stop_clears: assert property (stop_set && clk_en && !busy |-> ##[1:2]
		(!stop_flag && !not_ack_interrupt_flag))
		else $error("idle stop not cleared");
	a_end_clears: assert property ($fell(busy) |-> ##[0:1]
		(!stop_flag && !not_ack_interrupt_flag))
		else $error("flags left after stop");
endmodule // i2c_rd_chk

bind i2c_rd_ctrl i2c_rd_chk u_chk (.*);

/* File: i2c_slave_model.sv */
// Behavioural slave: acks the third address byte unless nak_addr is set, then sends bytes.
// Assumes pulled-up lines and an arm pulse just before each START.
`timescale 1ns/1ps
module i2c_slave_model (
	input wire scl,
	input wire sda,
	input wire arm,
	input wire nak_addr,
	input wire stretch,
	input wire [7:0] base,
	output reg scl_oe,
	output reg sda_oe,
	output reg [7:0] addr_seen,
	output reg [3:0] nbytes,
	output reg stop_seen
);
	integer n;
	reg done;
	wire [7:0] val = base + 8'h3b * nbytes;
	initial begin
		{scl_oe, sda_oe, addr_seen, nbytes, stop_seen, done} = 0;
		n = 0;
	end
	always @(posedge scl or posedge arm) begin
		if (arm) begin
			{n, nbytes, done, stop_seen} = 0;
		end else begin
			n = n + 1;
			if (n >= 2 && n <= 9)
				addr_seen = {addr_seen[6:0], sda};
			if (n == 10)
				done = nak_addr;
			if (n > 10 && (n - 10) % 9 == 0) begin
				nbytes = nbytes + 1;
				done = sda;
			end
		end
	end
	always @(negedge scl) begin
		if (n == 9)
			sda_oe = !nak_addr;
		else
			sda_oe = n >= 10 && !done && (n - 10) % 9 < 8 && !val[7 - (n - 10) % 9];
		if (stretch) begin
			scl_oe = 1;
			#200 scl_oe = 0;
		end
	end
	always @(posedge sda) begin
		if (scl)
			stop_seen = 1;
	end
endmodule // i2c_slave_model

/* File: tb.sv */
// Self-checking bench for the ten-bit read controller and a slave model.
// Assumes pull-ups on both lines and a 20 ns system clock.
`timescale 1ns/1ps
module tb;
	reg clk, rst_b, restart_req, stop_set, flush_req, nak_ctrl, txi_clr;
	reg data_wr, data_rd, arm, nak_addr, stretch, clk_en;
	reg [7:0] data_wdata, base;
	wire [7:0] data_rdata, addr_seen;
	wire [3:0] m_nb;
	wire stop_flag, txf, nakf, rxf, busy, scl_oe, sda_oe, m_scl, m_sda, m_stop;
	integer miscompares, n_compared;
	wire scl = !(scl_oe | m_scl);
	wire sda = !(sda_oe | m_sda);
	i2c_rd_ctrl #(.QTR_CYC(2)) u_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
		.restart_req(restart_req), .stop_set(stop_set), .flush_req(flush_req),
		.nak_ctrl(nak_ctrl), .txi_clr(txi_clr), .data_wr(data_wr),
		.data_wdata(data_wdata), .data_rd(data_rd), .data_rdata(data_rdata),
		.stop_flag(stop_flag), .transmit_interrupt_flag(txf),
		.not_ack_interrupt_flag(nakf), .receive_data_full_flag(rxf), .busy(busy),
		.scl_i(scl), .scl_o(), .scl_oe(scl_oe), .sda_i(sda), .sda_o(), .sda_oe(sda_oe));
	i2c_slave_model u_slave (.scl(scl), .sda(sda), .arm(arm), .nak_addr(nak_addr),
		.stretch(stretch), .base(base), .scl_oe(m_scl), .sda_oe(m_sda),
		.addr_seen(addr_seen), .nbytes(m_nb), .stop_seen(m_stop));
	initial begin
		clk = 0;
		forever #10 clk = !clk;
	end
	task chk(input [7:0] seen, input [7:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp) begin
				miscompares = miscompares + 1;
				$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task final_report;
		begin
			if (miscompares == 0 && n_compared > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task xfer(input integer nb, input na);
		integer i;
		reg [7:0] a;
		begin
			a = $urandom;
			base = $urandom;
			stretch = $urandom;
			nak_addr = na;
			data_wr = 1;
			data_wdata = a;
			@(negedge clk);
			data_wr = 0;
			restart_req = 1;
			arm = 1;
			chk(data_rdata, a);
			chk(txf, 0);
			@(negedge clk);
			{restart_req, arm} = 0;
			chk(busy, 1);
			fork
				begin
					wait (m_nb == nb - 1);
					@(negedge clk) nak_ctrl = 1;
				end
			join_none
			wait (rxf || nakf) @(negedge clk);
			chk(addr_seen, {5'h1e, a[2:1], 1'b1});
			chk(txf, 1);
			if (na) begin
				chk(nakf, 1);
				{stop_set, flush_req, txi_clr} = 3'h7;
				@(negedge clk);
				{stop_set, flush_req, txi_clr} = 0;
				chk(txf, 0);
			end else begin
				for (i = 0; i < nb; i = i + 1) begin
					wait (rxf) repeat (i ? 1 + $urandom % 50 : 700) @(negedge clk);
					if (i == 0)
						chk(m_nb, nb < 3 ? nb : 3);
					chk(rxf, 1);
					chk(data_rdata, base + 8'h3b * i);
					data_rd = 1;
					@(negedge clk);
					data_rd = 0;
					chk(rxf, 0);
				end
				wait (nakf) @(negedge clk);
				chk(m_nb, nb);
				stop_set = 1;
				@(negedge clk);
				stop_set = 0;
			end
			wait (!busy) @(negedge clk);
			chk({stop_flag, nakf, rxf}, 0);
			chk(m_stop, 1);
			nak_ctrl = 0;
		end
	endtask
	initial begin
		{rst_b, restart_req, stop_set, flush_req, nak_ctrl, txi_clr, data_wr} = 0;
		{data_rd, arm, nak_addr, stretch, data_wdata} = 0;
		clk_en = 1;
		miscompares = 0;
		n_compared = 0;
		base = $urandom(32'h035b);
		repeat (10) @(negedge clk);
		rst_b = 1;
		chk({busy, stop_flag, txf, nakf, rxf, scl_oe, sda_oe}, 0);
		stop_set = 1;
		@(negedge clk);
		stop_set = 0;
		@(negedge clk);
		chk(stop_flag, 0);
		clk_en = 0;
		data_wr = 1;
		data_wdata = 8'ha5;
		@(negedge clk);
		{clk_en, data_wr} = 2'h2;
		chk(data_rdata, 8'h00);
		xfer(5, 0);
		xfer(1, 1);
		xfer(2, 0);
		xfer(1, 0);
		final_report;
	end
	initial begin
		#400000;
		miscompares = miscompares + 1;
		final_report;
	end
endmodule // tb
